// ---- test/fpc_config_regs_sva.sv ----
// Checker for the floppy power and parallel-port registers.
// Assumes it is bound to fpc_config_regs and sees only that module's ports.
`timescale 1ns/1ps

module fpc_config_regs_chk (
  // Clock, reset and APB.
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  // Pins, floppy core and FIFO.
  input wire logic                    isa_reset_drive,
  input wire fpc_pkg::fpc_fdc_stat_t  fdc_status,
  input wire fpc_pkg::fpc_fdc_ctrl_t  fdc_ctrl,
  input wire fpc_pkg::fpc_fifo_stat_t fifo_status,
  input wire fpc_pkg::fpc_fifo_req_t  fifo_req
);
  import fpc_pkg::*;
  logic [3:0] hi_cnt;
  logic [3:0] since_drv;
  logic [2:0] busy_cnt;

  // Decoded accesses and the expected idle and request conditions.
  wire wr44 = psel && penable && pwrite && paddr == 8'h44;
  wire rd44 = psel && penable && !pwrite && paddr == 8'h44;
  wire idle_c = fdc_status.main_status == FDC_IDLE_STATUS && !fdc_status.irq_active &&
                fdc_status.head_unload_expired;
  wire [4:0] room = FIFO_DEPTH - fifo_status.fill_count;
  wire req_exp = fifo_status.reverse ? fifo_status.fill_count >= fifo_req.rev_threshold :
                 room >= fifo_req.fwd_threshold;

  // Counts reset drive time, time since it dropped, and time away from idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 4'h0;
      since_drv <= 4'hf;
      busy_cnt <= 3'h0;
    end else begin
      hi_cnt <= !isa_reset_drive ? 4'h0 : (hi_cnt == 4'hf ? hi_cnt : hi_cnt + 4'h1);
      since_drv <= isa_reset_drive ? 4'h0 : (since_drv == 4'hf ? since_drv : since_drv + 4'h1);
      busy_cnt <= idle_c ? 3'h0 : (busy_cnt == 3'h7 ? busy_cnt : busy_cnt + 3'h1);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rh_set; wr44 && pwdata[2] |-> ##2 fdc_ctrl.reset; endproperty
  a_rh_set: assert property (p_rh_set) else $error("reset hold not applied");
  property p_ds_rise; $rose(fdc_ctrl.direct_sleep) |-> $past(wr44 && pwdata[0], 2); endproperty
  a_ds_rise: assert property (p_ds_rise) else $error("direct sleep without write");
  property p_ds_fall; $fell(fdc_ctrl.direct_sleep) |-> $past(wr44, 2) || since_drv < 4'hc;
  endproperty
  a_ds_fall: assert property (p_ds_fall) else $error("direct sleep dropped alone");
  property p_ae_off; wr44 && !pwdata[3] |-> ##2 !fdc_ctrl.auto_sleep [*2]; endproperty
  a_ae_off: assert property (p_ae_off) else $error("auto sleep while disabled");
  property p_auto_idle; busy_cnt >= 3'h3 |-> !fdc_ctrl.auto_sleep; endproperty
  a_auto_idle: assert property (p_auto_idle) else $error("auto sleep while busy");
  property p_drv; hi_cnt >= 4'h6 |-> fdc_ctrl.reset && !fdc_ctrl.direct_sleep; endproperty
  a_drv: assert property (p_drv) else $error("reset drive not applied");
  property p_idle_rd; rd44 |-> prdata[1] == $past(idle_c, 2); endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("idle flag wrong");
  property p_thr;
    fifo_req.fwd_threshold == THR_FWD_HIGH || fifo_req.fwd_threshold == THR_LOW |->
      fifo_req.rev_threshold == (fifo_req.fwd_threshold == THR_LOW ? THR_LOW : THR_REV_HIGH);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold pair wrong");
  property p_req;
    $stable(fifo_status) && $stable(fifo_req) |-> fifo_req.request == (fifo_req.active && req_exp);
  endproperty
  a_req: assert property (p_req) else $error("fifo request wrong");

  // Main scenarios reached.
  c_rd44: cover property (rd44);
  c_req: cover property ($rose(fifo_req.request));
  c_ds: cover property ($rose(fdc_ctrl.direct_sleep));
endmodule

bind fpc_config_regs fpc_config_regs_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .isa_reset_drive(isa_reset_drive),
  .fdc_status(fdc_status), .fdc_ctrl(fdc_ctrl), .fifo_status(fifo_status),
  .fifo_req(fifo_req)
);

// ---- test/fpc_config_regs_tb_top.sv ----
// Self-checking bench for the floppy power and parallel-port registers.
// Assumes the far-side model stands in for the cores.
`timescale 1ns/1ps

module fpc_config_regs_tb_top;
  import fpc_pkg::*;
  logic pclk, pready, pslverr, irq, rd_err;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic isa_reset_drive = 1'b0, ecr_write = 1'b0, busy = 1'b0, reverse = 1'b0, isa_fifo = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [1:0] mode_strap = 2'h2;
  logic [2:0] ecr_mode = 3'h0;
  logic [4:0] fill = 5'h0;
  fpc_cfg_t cfg_strap = FPC_CFG_SW_A;
  fpc_fdc_stat_t fdc_status;
  fpc_fdc_ctrl_t fdc_ctrl;
  fpc_fifo_stat_t fifo_status;
  fpc_fifo_req_t fifo_req;
  int errors = 0, tests_run = 0;

  fpc_config_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .isa_reset_drive(isa_reset_drive), .cfg_strap(cfg_strap),
    .mode_strap(mode_strap), .fdc_status(fdc_status), .fdc_ctrl(fdc_ctrl),
    .ecr_write(ecr_write), .ecr_mode(ecr_mode), .fifo_status(fifo_status),
    .fifo_req(fifo_req), .irq(irq));
  fpc_far_model far_u (.pclk(pclk), .presetn(presetn), .busy(busy), .fill(fill),
    .reverse(reverse), .isa_fifo(isa_fifo), .fdc_ctrl(fdc_ctrl), .fdc_status(fdc_status),
    .fifo_status(fifo_status));

  // Free-running 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints counts and verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      complete_run();
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask

  task automatic ctl(input logic [2:0] e);
    cyc(4);
    chk({29'h0, fdc_ctrl}, {29'h0, e});
  endtask

  // Sets fill and direction, then checks the request.
  task automatic req(input logic [4:0] f, input logic r, input logic e);
    fill <= f;
    reverse <= r;
    cyc(4);
    chk({31'h0, fifo_req.request}, {31'h0, e});
  endtask

  task automatic pport_extended_control(input logic [2:0] m);
    @(posedge pclk);
    ecr_write <= 1'b1;
    ecr_mode <= m;
    @(posedge pclk);
    ecr_write <= 1'b0;
    cyc(2);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    cyc(10);
    presetn <= 1'b1;
    cyc(8);
  endtask

  // Main sequence.
  initial begin
    for (int c = 0; c < 4; c++) begin
      cfg_strap <= fpc_cfg_t'(c);
      do_reset();
      rd(8'h80, (c == 3) ? 32'h40 : 32'h0);
    end
    cfg_strap <= FPC_CFG_SW_A;
    do_reset();
    $display("test strap done");
    rd(8'h44, 32'h2);
    rd(8'hc4, 32'h0);
    rd(8'h84, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
    apb(1'b1, 8'h44, 32'hff);
    rd(8'h44, 32'hf);
    ctl(3'h6);
    cyc(120);
    apb(1'b1, 8'h44, 32'hc);
    ctl(3'h4);
    apb(1'b1, 8'h44, 32'h8);
    ctl(3'h1);
    busy <= 1'b1;
    ctl(3'h0);
    rd(8'h44, 32'h8);
    busy <= 1'b0;
    cyc(12);
    rd(8'h44, 32'ha);
    rd(8'hc0, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'hc4, 32'h3f);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'hc4, 32'h0);
    apb(1'b1, 8'hc0, 32'h3);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    $display("test floppy done");
    apb(1'b1, 8'h44, 32'h9);
    ctl(3'h3);
    isa_reset_drive <= 1'b1;
    cyc(5);
    ctl(3'h4);
    isa_reset_drive <= 1'b0;
    cyc(8);
    rd(8'h44, 32'ha);
    ctl(3'h1);
    rd(8'hc0, 32'h4);
    apb(1'b1, 8'hc0, 32'h3f);
    apb(1'b1, 8'h44, 32'h0);
    ctl(3'h0);
    $display("test reset drive done");
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h80, 32'h80 | (32'(m) << 5));
      rd(8'h80, 32'h80 | (32'(m) << 5));
    end
    cyc(2);
    chk({22'h0, fifo_req.fwd_threshold, fifo_req.rev_threshold},
        {22'h0, THR_FWD_HIGH, THR_REV_HIGH});
    apb(1'b1, 8'h80, 32'h40);
    rd(8'h80, 32'hc0);
    apb(1'b1, 8'h80, 32'h60);
    rd(8'h80, 32'hc0);
    pport_extended_control(ECR_ECP);
    rd(8'h80, 32'he0);
    apb(1'b1, 8'h80, 32'h60);
    rd(8'h80, 32'he0);
    req(5'hf, 1'b1, 1'b1);
    req(5'he, 1'b1, 1'b0);
    req(5'hf, 1'b0, 1'b1);
    req(5'h10, 1'b0, 1'b0);
    pport_extended_control(ECR_ISA);
    rd(8'h80, 32'h80);
    req(5'h0, 1'b0, 1'b0);
    isa_fifo <= 1'b1;
    req(5'h0, 1'b0, 1'b1);
    apb(1'b1, 8'h80, 32'h0);
    req(5'h8, 1'b0, 1'b1);
    req(5'h9, 1'b0, 1'b0);
    req(5'h8, 1'b1, 1'b1);
    req(5'h7, 1'b1, 1'b0);
    pport_extended_control(ECR_PS2);
    rd(8'h80, 32'h20);
    req(5'h8, 1'b1, 1'b0);
    rd(8'hc0, 32'h18);
    $display("test parallel port done");
    complete_run();
  end
endmodule

// ---- test/fpc_far_model.sv ----
// Model of the floppy core and parallel-port FIFO facing the block.
// Assumes the bench steers busy, fill, reverse and isa_fifo.
`timescale 1ns/1ps

module fpc_far_model #(
  parameter logic [3:0] UNLOAD = 4'h6
) (
  // Clock and reset.
  input wire logic                    pclk,
  input wire logic                    presetn,
  // Bench steering.
  input wire logic                    busy,
  input wire logic [4:0]              fill,
  input wire logic                    reverse,
  input wire logic                    isa_fifo,
  // Block side.
  input wire fpc_pkg::fpc_fdc_ctrl_t  fdc_ctrl,
  output fpc_pkg::fpc_fdc_stat_t      fdc_status,
  output fpc_pkg::fpc_fifo_stat_t     fifo_status
);
  import fpc_pkg::*;
  logic [3:0] unload;
  logic       busy_q;
  logic       done;

  // Head unload timer restarts on each command; a reset unloads at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unload <= 4'h0;
      busy_q <= 1'b0;
      done <= 1'b0;
      fifo_status <= '0;
    end else begin
      busy_q <= busy;
      done <= busy_q && !busy;
      fifo_status <= '{fill, reverse, isa_fifo};
      unload <= fdc_ctrl.reset ? 4'h0 : (busy ? UNLOAD : (unload != 4'h0 ? unload - 4'h1 : unload));
    end
  end

  // Core status; completion raises the interrupt for a cycle.
  assign fdc_status = '{busy_q ? 8'h10 : FDC_IDLE_STATUS, done, unload == 4'h0};
endmodule

// ---- verilog/fpc_config_regs.sv ----
// Floppy power and parallel-port configuration registers behind an APB slave.
// Assumes the cores and extended control run on pclk; pins are synchronised here.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

// What this block does
// [R1] Auto-sleep enable allows auto powerdown when idle; clear, never.
// [R2] Reset hold set keeps the floppy core in reset like the reset drive.
// [R3] Software keeps reset hold set for at least 1.13 us.
// [R4] Idle flag sets at main status 80h, core irq off, heads unloaded.
// [R5] The idle flag clears on leaving idle and ignores writes.
// [R6] Writing one to direct sleep puts the core in direct powerdown.
// [R7] Software leaves direct powerdown by clearing the bit, then a reset.
// [R8] The reset drive also ends direct powerdown.
// [R9] Threshold select acts only in ECP or ISA-compatible FIFO mode.
// [R10] Threshold select one gives 1 forward, 15 reverse; zero gives 8.
// [R11] Threshold select takes writes only in ISA or PS/2 mode.
// [R12] A FIFO request rises at the reverse fill or forward room mark.
// [R13] The two-bit mode field picks ISA, PS/2, EPP or ECP operation.
// [R14] Mode loads its strap only in extended hardware config, else ISA.
// [R15] Codes 00 ISA, 01 PS/2, 10 EPP, 11 ECP; software never writes 11.
// [R16] Extended control forces 11 for ECP and matches ISA or PS/2.
// [R17] Reset hold and direct sleep never clear themselves.
module fpc_config_regs (
  // APB clock and reset.
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [fpc_pkg::APB_AW-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Pins: ISA reset drive and power-up straps.
  input  wire logic                          isa_reset_drive,
  input  wire fpc_pkg::fpc_cfg_t             cfg_strap,
  input  wire logic [1:0]                    mode_strap,
  // Floppy controller core.
  input  wire fpc_pkg::fpc_fdc_stat_t        fdc_status,
  output fpc_pkg::fpc_fdc_ctrl_t             fdc_ctrl,
  // Extended control register mode updates.
  input  wire logic                          ecr_write,
  input  wire logic [2:0]                    ecr_mode,
  // Parallel-port FIFO.
  input  wire fpc_pkg::fpc_fifo_stat_t       fifo_status,
  output fpc_pkg::fpc_fifo_req_t             fifo_req,
  // Interrupt.
  output logic                               irq
);
  import fpc_pkg::*;

  // Stored register state.
  logic              floppy_auto_sleep_enable;
  logic              floppy_reset_hold;
  logic              floppy_idle_flag;
  logic              floppy_direct_sleep;
  logic              pport_fifo_threshold_select;
  fpc_pmode_t        pport_protocol_mode;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_mask;
  logic [2:0]        strap_count;
  logic [7:0]        hold_count;
  logic              bus_reset_seen;

  // Synchronised pin levels.
  logic [4:0]        pins_sync;
  wire               bus_reset   = pins_sync[4];
  wire  fpc_cfg_t    cfg_sync    = fpc_cfg_t'(pins_sync[3:2]);
  wire  [1:0]        mode_sync   = pins_sync[1:0];

  fpc_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({isa_reset_drive, cfg_strap, mode_strap}),
    .q       (pins_sync)
  );

  // APB phase and address decode.
  wire       apb_setup    = psel & ~penable;
  wire       apb_access   = psel & penable;
  wire       apb_write    = apb_access & pwrite;
  wire       addr_aligned = (paddr[1:0] == 2'h0);
  wire [5:0] addr_index   = paddr[APB_AW-1:2];
  wire       hit_fps      = addr_aligned & (addr_index == IDX_FLOPPY_POWER);
  wire       hit_ppc      = addr_aligned & (addr_index == IDX_PPORT_CONFIG);
  wire       hit_ists     = addr_aligned & (addr_index == IDX_IRQ_STATUS);
  wire       hit_imask    = addr_aligned & (addr_index == IDX_IRQ_MASK);
  wire       hit_any      = hit_fps | hit_ppc | hit_ists | hit_imask;
  wire       wr_fps       = apb_write & hit_fps;
  wire       wr_ppc       = apb_write & hit_ppc;
  wire       wr_ists      = apb_write & hit_ists;
  wire       wr_imask     = apb_write & hit_imask;

  // Zero wait states; unmapped or unaligned addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = apb_access & ~hit_any;

  // Read data selection, registered during the setup phase.
  wire [7:0] rd_fps  = {4'h0, floppy_auto_sleep_enable, floppy_reset_hold,
                        floppy_idle_flag, floppy_direct_sleep};
  wire [7:0] rd_ppc  = {pport_fifo_threshold_select, pport_protocol_mode, 5'h00};
  wire [31:0] rd_mux = hit_fps   ? {24'h000000, rd_fps} :
                       hit_ppc   ? {24'h000000, rd_ppc} :
                       hit_ists  ? {26'h0000000, irq_status} :
                       hit_imask ? {26'h0000000, irq_mask} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Floppy idle detection from the core's status.
  wire fdc_idle_now = (fdc_status.main_status == FDC_IDLE_STATUS) &
                      ~fdc_status.irq_active &
                      fdc_status.head_unload_expired; // see [R4]
  wire idle_enter = fdc_idle_now & ~floppy_idle_flag;
  wire idle_exit  = ~fdc_idle_now & floppy_idle_flag;

  // Bus reset edge and reset-hold duration tracking.
  wire bus_reset_rise  = bus_reset & ~bus_reset_seen;
  wire hold_released   = wr_fps & floppy_reset_hold & ~pwdata[FPS_RESET_HOLD];
  wire short_reset     = hold_released & (hold_count < FLOPPY_RESET_MIN_CNT); // see [R3]

  // Floppy power register; the idle flag follows hardware.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      floppy_auto_sleep_enable <= FLOPPY_POWER_RST[FPS_AUTO_SLEEP];
      floppy_reset_hold        <= FLOPPY_POWER_RST[FPS_RESET_HOLD];
      floppy_idle_flag         <= FLOPPY_POWER_RST[FPS_IDLE];
      floppy_direct_sleep      <= FLOPPY_POWER_RST[FPS_DIRECT_SLEEP];
    end else begin
      floppy_idle_flag <= fdc_idle_now; // see [R4] see [R5]
      if (wr_fps) begin
        floppy_auto_sleep_enable <= pwdata[FPS_AUTO_SLEEP];
        floppy_reset_hold        <= pwdata[FPS_RESET_HOLD]; // see [R17]
      end
      if (bus_reset) begin
        floppy_direct_sleep <= 1'b0; // see [R8]
      end else if (wr_fps) begin
        floppy_direct_sleep <= pwdata[FPS_DIRECT_SLEEP]; // see [R6] see [R7] see [R17]
      end
    end
  end

  // Saturating count of how long reset hold has been set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_count     <= 8'h00;
      bus_reset_seen <= 1'b0;
    end else begin
      bus_reset_seen <= bus_reset;
      if (!floppy_reset_hold) begin
        hold_count <= 8'h00;
      end else if (hold_count != 8'hff) begin
        hold_count <= 8'(hold_count + 8'h01);
      end
    end
  end

  // Control toward the floppy core, registered.
  wire next_fdc_reset  = floppy_reset_hold | bus_reset; // see [R2]
  wire next_fdc_dsleep = floppy_direct_sleep & ~bus_reset; // see [R6] see [R8]
  wire next_fdc_asleep = floppy_auto_sleep_enable & floppy_idle_flag &
                         ~next_fdc_reset; // see [R1]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdc_ctrl <= '0;
    end else begin
      fdc_ctrl.reset        <= next_fdc_reset;
      fdc_ctrl.direct_sleep <= next_fdc_dsleep;
      fdc_ctrl.auto_sleep   <= next_fdc_asleep;
    end
  end

  // Straps load once the synchroniser has settled after reset.
  wire strap_load = (strap_count == STRAP_LOAD_AT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_count <= 3'h0;
    end else if (strap_count != STRAP_DONE) begin
      strap_count <= 3'(strap_count + 3'h1);
    end
  end

  // A strapped ECP code is illegal at power-up and falls back to ISA-compatible.
  wire        strap_is_ext = (cfg_sync == FPC_CFG_HW_EXT);
  wire        strap_legal  = (fpc_pmode_t'(mode_sync) != FPC_MODE_ECP);
  wire fpc_pmode_t strap_mode = (strap_is_ext & strap_legal) ? fpc_pmode_t'(mode_sync)
                                                             : FPC_MODE_ISA; // see [R14]

  // Extended control updates of the mode field.
  wire ecr_sets_isa = ecr_write & (ecr_mode == ECR_ISA);
  wire ecr_sets_ps2 = ecr_write & (ecr_mode == ECR_PS2);
  wire ecr_sets_ecp = ecr_write & (ecr_mode == ECR_ECP);
  wire ecr_hit      = ecr_sets_isa | ecr_sets_ps2 | ecr_sets_ecp;
  wire fpc_pmode_t ecr_target = ecr_sets_ecp ? FPC_MODE_ECP :
                                ecr_sets_ps2 ? FPC_MODE_PS2 : FPC_MODE_ISA; // see [R16]
  wire ecr_changed  = ecr_hit & (ecr_target != pport_protocol_mode);

  // Software mode writes; an ECP code from software is dropped.
  wire fpc_pmode_t sw_mode = fpc_pmode_t'(pwdata[PPC_MODE_HI:PPC_MODE_LO]);
  wire sw_mode_ok = wr_ppc & (sw_mode != FPC_MODE_ECP); // see [R15]

  // Strap load outranks extended control, which outranks software.
  wire fpc_pmode_t next_mode = strap_load ? strap_mode :
                               ecr_hit    ? ecr_target :
                               sw_mode_ok ? sw_mode : pport_protocol_mode; // see [R13]

  // Threshold select writes are accepted only in the two basic modes.
  wire thr_writable = (pport_protocol_mode == FPC_MODE_ISA) |
                      (pport_protocol_mode == FPC_MODE_PS2);
  wire thr_take     = wr_ppc & thr_writable; // see [R11]
  wire thr_refused  = wr_ppc & ~thr_writable &
                      (pwdata[PPC_THRESHOLD] != pport_fifo_threshold_select);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pport_fifo_threshold_select <= PPORT_CONFIG_RST[PPC_THRESHOLD];
      pport_protocol_mode <= fpc_pmode_t'(PPORT_CONFIG_RST[PPC_MODE_HI:PPC_MODE_LO]);
    end else begin
      pport_protocol_mode <= next_mode;
      if (thr_take) begin
        pport_fifo_threshold_select <= pwdata[PPC_THRESHOLD];
      end
    end
  end

  // FIFO threshold selection and request generation.
  wire       thr_active = (pport_protocol_mode == FPC_MODE_ECP) |
                          ((pport_protocol_mode == FPC_MODE_ISA) &
                           fifo_status.isa_fifo_mode); // see [R9]
  wire [4:0] fwd_thr    = pport_fifo_threshold_select ? THR_FWD_HIGH : THR_LOW; // see [R10]
  wire [4:0] rev_thr    = pport_fifo_threshold_select ? THR_REV_HIGH : THR_LOW; // see [R10]
  wire [4:0] free_room  = 5'(FIFO_DEPTH - fifo_status.fill_count);
  wire       rev_hit    = fifo_status.fill_count >= rev_thr;
  wire       fwd_hit    = free_room >= fwd_thr;
  wire       next_req   = thr_active &
                          (fifo_status.reverse ? rev_hit : fwd_hit); // see [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_req <= '0;
    end else begin
      fifo_req.active        <= thr_active;
      fifo_req.fwd_threshold <= fwd_thr;
      fifo_req.rev_threshold <= rev_thr;
      fifo_req.request       <= next_req;
    end
  end

  // Interrupt events; a new event wins over a write-one clear in the same cycle.
  logic [IRQ_W-1:0] irq_events;
  always_comb begin
    irq_events                  = '0;
    irq_events[IRQ_IDLE_ENTER]  = idle_enter;
    irq_events[IRQ_IDLE_EXIT]   = idle_exit;
    irq_events[IRQ_BUS_RESET]   = bus_reset_rise;
    irq_events[IRQ_ECR_MODE]    = ecr_changed;
    irq_events[IRQ_THR_REFUSED] = thr_refused;
    irq_events[IRQ_SHORT_RESET] = short_reset;
  end

  wire [IRQ_W-1:0] irq_clear       = wr_ists ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
      irq_mask   <= IRQ_MASK_RST;
    end else begin
      irq_status <= next_irq_status;
      if (wr_imask) begin
        irq_mask <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign irq = |(irq_status & irq_mask);

endmodule

// ---- verilog/fpc_pkg.sv ----
// Constants and types of the floppy power and parallel-port registers.
// Assumes a 100 MHz pclk and an APB master with 32-bit data and 8-bit byte addresses.
package fpc_pkg;

  // Bus geometry.
  localparam int APB_AW = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_FLOPPY_POWER = 6'h11;
  localparam logic [5:0] IDX_PPORT_CONFIG = 6'h20;
  localparam logic [5:0] IDX_IRQ_STATUS   = 6'h30;
  localparam logic [5:0] IDX_IRQ_MASK     = 6'h31;

  // Field positions of the floppy power and status register.
  localparam int FPS_AUTO_SLEEP   = 3;
  localparam int FPS_RESET_HOLD   = 2;
  localparam int FPS_IDLE         = 1;
  localparam int FPS_DIRECT_SLEEP = 0;

  // Field positions of the parallel-port configuration register.
  localparam int PPC_THRESHOLD = 7;
  localparam int PPC_MODE_HI   = 6;
  localparam int PPC_MODE_LO   = 5;

  // Reset values.
  localparam logic [7:0] FLOPPY_POWER_RST = 8'h00;
  localparam logic [7:0] PPORT_CONFIG_RST = 8'h00;
  localparam logic [5:0] IRQ_MASK_RST     = 6'h00;

  // Main status value of an idle floppy controller.
  localparam logic [7:0] FDC_IDLE_STATUS = 8'h80;

  // Parallel-port protocol mode field encoding.
  typedef enum logic [1:0] {
    FPC_MODE_ISA = 2'h0,
    FPC_MODE_PS2 = 2'h1,
    FPC_MODE_EPP = 2'h2,
    FPC_MODE_ECP = 2'h3
  } fpc_pmode_t;

  // Extended control mode codes that set the mode field.
  localparam logic [2:0] ECR_ISA = 3'h0;
  localparam logic [2:0] ECR_PS2 = 3'h1;
  localparam logic [2:0] ECR_ECP = 3'h3;

  // Configuration variants strapped at power-up.
  typedef enum logic [1:0] {
    FPC_CFG_SW_A     = 2'h0,
    FPC_CFG_SW_B     = 2'h1,
    FPC_CFG_HW_BASIC = 2'h2,
    FPC_CFG_HW_EXT   = 2'h3
  } fpc_cfg_t;

  // FIFO geometry and thresholds in bytes.
  localparam logic [4:0] FIFO_DEPTH   = 5'h10;
  localparam logic [4:0] THR_FWD_HIGH = 5'h01;
  localparam logic [4:0] THR_REV_HIGH = 5'h0f;
  localparam logic [4:0] THR_LOW      = 5'h08;

  // Timing.
  localparam real CLK_PERIOD_NS       = 10.0;
  localparam real FLOPPY_RESET_MIN_US = 1.13;
  localparam int  FLOPPY_RESET_MIN_CYC =
    int'($ceil(FLOPPY_RESET_MIN_US * 1000.0 / CLK_PERIOD_NS));
  localparam logic [7:0] FLOPPY_RESET_MIN_CNT = 8'(FLOPPY_RESET_MIN_CYC);
  localparam logic [2:0] STRAP_LOAD_AT = 3'h4;
  localparam logic [2:0] STRAP_DONE    = 3'h5;

  // Interrupt status and mask bit positions.
  localparam int IRQ_IDLE_ENTER  = 0;
  localparam int IRQ_IDLE_EXIT   = 1;
  localparam int IRQ_BUS_RESET   = 2;
  localparam int IRQ_ECR_MODE    = 3;
  localparam int IRQ_THR_REFUSED = 4;
  localparam int IRQ_SHORT_RESET = 5;
  localparam int IRQ_W           = 6;

  // Status from the floppy controller core.
  typedef struct packed {
    logic [7:0] main_status;
    logic       irq_active;
    logic       head_unload_expired;
  } fpc_fdc_stat_t;

  // Control toward the floppy controller core.
  typedef struct packed {
    logic reset;
    logic direct_sleep;
    logic auto_sleep;
  } fpc_fdc_ctrl_t;

  // Status from the parallel-port FIFO.
  typedef struct packed {
    logic [4:0] fill_count;
    logic       reverse;
    logic       isa_fifo_mode;
  } fpc_fifo_stat_t;

  // Threshold and request toward the parallel-port FIFO.
  typedef struct packed {
    logic       active;
    logic [4:0] fwd_threshold;
    logic [4:0] rev_threshold;
    logic       request;
  } fpc_fifo_req_t;

endpackage

// ---- verilog/fpc_sync.sv ----
// Three-stage synchroniser for pin inputs of the configuration block.
// Assumes pins change slowly against pclk; each bit is filtered alone.
`timescale 1ns/1ps

module fpc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Raw pin levels and the filtered result.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Stage one feeds only stage two; a change passes once stages two and three agree.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          stage1[i] <= d[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            q[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule
